// *** inc/rmpm_defines.vh ***
`ifndef RMPM_DEFINES_VH
`define RMPM_DEFINES_VH

// register byte offsets on the apb bus
`define RMPM_OFF_CTRL 8'h00
`define RMPM_OFF_MODE 8'h04
`define RMPM_OFF_PF_DIR 8'h08
`define RMPM_OFF_PF_OUT 8'h0c
`define RMPM_OFF_PF_IN 8'h10
`define RMPM_OFF_FLAGS 8'h14
`define RMPM_OFF_INT_STAT 8'h18
`define RMPM_OFF_INT_MASK 8'h1c

// control register fields
`define RMPM_CTRL_S1_ALT 0
`define RMPM_CTRL_EXT_INT_REQ_CONFIGURABLE_EDGE 1

// mode status fields: straps in [3:0], host mode flag
`define RMPM_MODE_HOST 4
// strap positions on the flag pins
`define RMPM_STRAP_HOST 2
`define RMPM_STRAP_ACK 3

// flags register fields: fixed output flags [2:0], serial flag out
`define RMPM_FLAGS_S1FO 3

// interrupt status and mask bit positions
`define RMPM_INT_EXT_INT_REQ_CONFIGURABLE 0
`define RMPM_INT_LEVEL_INT_REQ_ONE 1
`define RMPM_INT_LEVEL_INT_REQ_ZERO 2
`define RMPM_INT_EDGE_INT_REQ 3
`define RMPM_INT_IRQ1 4
`define RMPM_INT_IRQ0 5
`define RMPM_NUM_INT 6

// reset values
`define RMPM_CTRL_RST 2'h0
`define RMPM_PF_DIR_RST 8'h00
`define RMPM_PF_OUT_RST 8'h00
`define RMPM_FLAGS_RST 4'h0
`define RMPM_INT_MASK_RST 6'h00

// interrupt pins share flag pins 7..4
`define RMPM_PF_IRQ_BASE 4

`endif

// *** src/rmpm_pin_mux.v ***
`timescale 1ns/1ns
`include "rmpm_defines.vh"

module rmpm_pin_mux (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg irq,
  input wire [7:0] pf_in,
  output reg [7:0] pf_out,
  output reg [7:0] pf_oe,
  output reg [2:0] fixed_flag_out,
  input wire [13:0] core_addr,
  input wire [23:0] core_wdata,
  input wire core_data_drive,
  input wire core_byte_access,
  input wire [7:0] core_byte_addr_hi,
  input wire [4:0] core_mem_select_n,
  output reg [23:0] core_rdata,
  output reg [13:0] ext_addr_bus_out,
  output reg [13:0] ext_addr_bus_oe,
  input wire [13:0] ext_addr_bus_in,
  output reg [23:0] ext_data_bus_out,
  output reg [23:0] ext_data_bus_oe,
  input wire [23:0] ext_data_bus_in,
  output reg [4:0] mem_select_n,
  input wire [15:0] host_core_rdata,
  input wire host_core_drive,
  input wire host_core_ack,
  output reg [15:0] host_core_ad,
  output reg host_write_strobe_n,
  output reg host_read_strobe_n,
  output reg host_addr_latch,
  output reg host_port_select_n,
  output reg host_mode,
  input wire s1_rfs_in,
  input wire s1_dr_in,
  input wire s1_tfs_in,
  input wire s1_dt_core,
  output reg s1_dt_out,
  output reg s1_rfs_core,
  output reg s1_dr_core,
  output reg s1_tfs_core,
  output reg serial1_flag_in
);

  // pin synchronisers: stage one feeds stage two only
  reg [7:0] pf_s1_q;
  reg [7:0] pf_s2_q;
  reg [7:0] pf_s3_q;
  reg [13:0] adr_s1_q;
  reg [13:0] adr_s2_q;
  reg [23:0] dat_s1_q;
  reg [23:0] dat_s2_q;
  reg [2:0] s1_s1_q;
  reg [2:0] s1_s2_q;
  reg [2:0] s1_s3_q;
  reg [3:0] strap_s1_q;
  reg [3:0] strap_s2_q;
  reg [3:0] strap_q;
  reg init_done_q;
  reg [1:0] ctrl_q;
  reg [7:0] pf_dir_q;
  reg [7:0] pf_val_q;
  reg [3:0] flags_q;
  reg [5:0] int_stat_q;
  reg [5:0] int_mask_q;
  reg [5:0] int_set;
  reg [7:0] pf_level;
  reg [31:0] rdata_d;
  reg addr_ok;
  wire [15:0] host_ad_pins;
  wire host_sel;
  wire wr_en;

  // strap sampling chain has no reset so it tracks the pins while reset is held
  always @(posedge pclk)
  begin
    strap_s1_q <= pf_in[3:0];
    strap_s2_q <= strap_s1_q;
  end

  // latch straps once, on the first edge after reset release
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_q <= 4'h0;
      init_done_q <= 1'b0;
    end
    else if (!init_done_q)
    begin
      strap_q <= strap_s2_q;
      init_done_q <= 1'b1;
    end
  end

  // two-flop synchronisers for every pin input
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pf_s1_q <= 8'hff;
      pf_s2_q <= 8'hff;
      pf_s3_q <= 8'hff;
      adr_s1_q <= 14'h0000;
      adr_s2_q <= 14'h0000;
      dat_s1_q <= 24'h000000;
      dat_s2_q <= 24'h000000;
      s1_s1_q <= 3'h7;
      s1_s2_q <= 3'h7;
      s1_s3_q <= 3'h7;
    end
    else
    begin
      pf_s1_q <= pf_in;
      pf_s2_q <= pf_s1_q;
      pf_s3_q <= pf_level;
      adr_s1_q <= ext_addr_bus_in;
      adr_s2_q <= adr_s1_q;
      dat_s1_q <= ext_data_bus_in;
      dat_s2_q <= dat_s1_q;
      s1_s1_q <= {s1_rfs_in, s1_dr_in, s1_tfs_in};
      s1_s2_q <= s1_s1_q;
      s1_s3_q <= s1_s2_q;
    end
  end

  // a driven flag pin reads back its own value, so an own flag can raise its interrupt
  always @*
  begin
    pf_level = (pf_dir_q & pf_val_q) | (~pf_dir_q & pf_s2_q);
  end

  // host port pins share address 13:1 and data 2:0
  assign host_ad_pins = {dat_s2_q[2:0], adr_s2_q[13:1]};
  assign host_sel = ~dat_s2_q[4];

  // interrupt events, all requests active low
  always @*
  begin
    int_set = 6'h00;
    if (ctrl_q[`RMPM_CTRL_EXT_INT_REQ_CONFIGURABLE_EDGE])
      int_set[`RMPM_INT_EXT_INT_REQ_CONFIGURABLE] = pf_s3_q[7] & ~pf_level[7];
    else
      int_set[`RMPM_INT_EXT_INT_REQ_CONFIGURABLE] = ~pf_level[7];
    int_set[`RMPM_INT_LEVEL_INT_REQ_ONE] = ~pf_level[6];
    int_set[`RMPM_INT_LEVEL_INT_REQ_ZERO] = ~pf_level[5];
    int_set[`RMPM_INT_EDGE_INT_REQ] = pf_s3_q[4] & ~pf_level[4];
    // serial pins only request interrupts in their alternate role
    if (ctrl_q[`RMPM_CTRL_S1_ALT])
    begin
      int_set[`RMPM_INT_IRQ1] = s1_s3_q[0] & ~s1_s2_q[0];
      int_set[`RMPM_INT_IRQ0] = s1_s3_q[2] & ~s1_s2_q[2];
    end
  end

  assign wr_en = psel & penable & pready & pwrite;

  // apb register file; a hardware set beats a same-cycle write-one clear
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `RMPM_CTRL_RST;
      pf_dir_q <= `RMPM_PF_DIR_RST;
      pf_val_q <= `RMPM_PF_OUT_RST;
      flags_q <= `RMPM_FLAGS_RST;
      int_mask_q <= `RMPM_INT_MASK_RST;
      int_stat_q <= 6'h00;
    end
    else
    begin
      int_stat_q <= int_set | (int_stat_q &
        ~((wr_en && paddr == `RMPM_OFF_INT_STAT) ? pwdata[5:0] : 6'h00));
      if (wr_en)
      begin
        case (paddr)
          `RMPM_OFF_CTRL: ctrl_q <= pwdata[1:0];
          `RMPM_OFF_PF_DIR: pf_dir_q <= pwdata[7:0];
          `RMPM_OFF_PF_OUT: pf_val_q <= pwdata[7:0];
          `RMPM_OFF_FLAGS: flags_q <= pwdata[3:0];
          `RMPM_OFF_INT_MASK: int_mask_q <= pwdata[5:0];
          default: ;
        endcase
      end
    end
  end

  // read mux and address decode
  always @*
  begin
    rdata_d = 32'h00000000;
    addr_ok = 1'b1;
    case (paddr)
      `RMPM_OFF_CTRL: rdata_d[1:0] = ctrl_q;
      `RMPM_OFF_MODE: rdata_d[4:0] = {strap_q[`RMPM_STRAP_HOST], strap_q};
      `RMPM_OFF_PF_DIR: rdata_d[7:0] = pf_dir_q;
      `RMPM_OFF_PF_OUT: rdata_d[7:0] = pf_val_q;
      `RMPM_OFF_PF_IN: rdata_d[7:0] = pf_level;
      `RMPM_OFF_FLAGS: rdata_d[3:0] = flags_q;
      `RMPM_OFF_INT_STAT: rdata_d[5:0] = int_stat_q;
      `RMPM_OFF_INT_MASK: rdata_d[5:0] = int_mask_q;
      default: addr_ok = 1'b0;
    endcase
  end

  // one wait state: pready rises in the second access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      irq <= 1'b0;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
      if (psel & penable & ~pready & ~pwrite)
        prdata <= rdata_d;
      // a bit being set counts now, so irq does not lag the status register by a cycle
      irq <= |(int_mask_q & (int_stat_q | int_set));
    end
  end

  // flag pins; strap pins stay inputs while reset holds the direction clear
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pf_out <= 8'h00;
      pf_oe <= 8'h00;
      fixed_flag_out <= 3'h0;
    end
    else
    begin
      pf_out <= pf_val_q;
      pf_oe <= pf_dir_q;
      fixed_flag_out <= flags_q[2:0];
    end
  end

  // second serial port: normal or alternate role, switchable at any time
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_dt_out <= 1'b0;
      s1_rfs_core <= 1'b1;
      s1_dr_core <= 1'b1;
      s1_tfs_core <= 1'b1;
      serial1_flag_in <= 1'b1;
    end
    else if (ctrl_q[`RMPM_CTRL_S1_ALT])
    begin
      s1_dt_out <= flags_q[`RMPM_FLAGS_S1FO];
      serial1_flag_in <= s1_s2_q[1];
      s1_rfs_core <= 1'b1;
      s1_dr_core <= 1'b1;
      s1_tfs_core <= 1'b1;
    end
    else
    begin
      s1_dt_out <= s1_dt_core;
      s1_rfs_core <= s1_s2_q[2];
      s1_dr_core <= s1_s2_q[1];
      s1_tfs_core <= s1_s2_q[0];
      serial1_flag_in <= 1'b1;
    end
  end

  // external bus and host port mux, steered only by the latched straps
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_addr_bus_out <= 14'h0000;
      ext_addr_bus_oe <= 14'h0000;
      ext_data_bus_out <= 24'h000000;
      ext_data_bus_oe <= 24'h000000;
      mem_select_n <= 5'h1f;
      core_rdata <= 24'h000000;
      host_core_ad <= 16'h0000;
      host_write_strobe_n <= 1'b1;
      host_read_strobe_n <= 1'b1;
      host_addr_latch <= 1'b0;
      host_port_select_n <= 1'b1;
      host_mode <= 1'b0;
    end
    else
    begin
      host_mode <= init_done_q & strap_q[`RMPM_STRAP_HOST];
      mem_select_n <= core_mem_select_n;
      if (!strap_q[`RMPM_STRAP_HOST])
      begin
        ext_addr_bus_out <= core_addr;
        ext_addr_bus_oe <= {14{init_done_q}};
        ext_data_bus_out <= core_byte_access ?
          {core_byte_addr_hi, core_wdata[15:0]} : core_wdata;
        ext_data_bus_oe <= {{8{core_data_drive | core_byte_access}},
          {16{core_data_drive}}};
        core_rdata <= dat_s2_q;
        host_core_ad <= 16'h0000;
        host_write_strobe_n <= 1'b1;
        host_read_strobe_n <= 1'b1;
        host_addr_latch <= 1'b0;
        host_port_select_n <= 1'b1;
      end
      else
      begin
        // address 0 and data 23:8 remain for external accesses
        ext_addr_bus_out <= {host_core_rdata[12:0], core_addr[0]};
        ext_addr_bus_oe <= {{13{host_core_drive & host_sel}}, 1'b1};
        ext_data_bus_out <= {core_wdata[23:8], 4'h0,
          1'b0, host_core_rdata[15:13]};
        // open-drain ack: release only while acknowledging, and with the ack strap set only while also selected
        ext_data_bus_oe <= {{16{core_data_drive}}, 4'h0,
          ~(host_core_ack & (host_sel | ~strap_q[`RMPM_STRAP_ACK])),
          {3{host_core_drive & host_sel}}};
        core_rdata <= {dat_s2_q[23:8], 8'h00};
        host_core_ad <= host_ad_pins;
        host_write_strobe_n <= dat_s2_q[7];
        host_read_strobe_n <= dat_s2_q[6];
        host_addr_latch <= dat_s2_q[5];
        host_port_select_n <= dat_s2_q[4];
      end
    end
  end

endmodule // rmpm_pin_mux

// *** bench/rmpm_pin_mux_chk.sv ***
`timescale 1ns/1ns
module rmpm_pin_mux_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire [7:0] pf_in,
  input wire [4:0] core_mem_select_n,
  input wire [4:0] mem_select_n,
  input wire host_mode,
  input wire [13:0] ext_addr_bus_oe,
  input wire [23:0] ext_data_bus_oe
);
  logic [1:0] cnt_q;
  logic strap_q;
  // edges since release; the mux must be settled once this saturates
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt_q <= 2'h0;
    else if (cnt_q != 2'h3)
      cnt_q <= cnt_q + 2'h1;
  // host strap as last seen under reset
  always @(posedge pclk)
    if (!presetn)
      strap_q <= pf_in[2];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_unmapped: assert property (pslverr |-> pready && (paddr > 8'h1c || paddr[1:0] != 2'h0))
    else $error("pslverr on mapped offset");
  a_ok_no_err: assert property (pready && paddr <= 8'h1c && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("pslverr without cause");
  a_mode_hold: assert property (cnt_q == 2'h3 |-> $stable(host_mode))
    else $error("mode moved");
  a_mode_strap: assert property (cnt_q == 2'h3 |-> host_mode == strap_q)
    else $error("mode not from strap");
  a_full_addr_drive: assert property (cnt_q == 2'h3 && !host_mode |-> &ext_addr_bus_oe)
    else $error("address bus not driven");
  a_host_strobe_in: assert property (cnt_q == 2'h3 && host_mode |-> ext_data_bus_oe[7:4] == 4'h0)
    else $error("host strobe pin driven");
  a_select_copy: assert property (1'b1 |=> mem_select_n == $past(core_mem_select_n))
    else $error("select not passed");
endmodule // rmpm_pin_mux_chk

bind rmpm_pin_mux rmpm_pin_mux_chk u_chk (
  .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .pf_in,
  .core_mem_select_n, .mem_select_n, .host_mode, .ext_addr_bus_oe, .ext_data_bus_oe
);

// *** bench/rmpm_far_model.sv ***
`timescale 1ns/1ns
module rmpm_far_model (
  input wire [7:0] pf_out,
  input wire [7:0] pf_oe,
  input wire [7:0] pf_drv,
  input wire [7:0] pf_val,
  input wire [13:0] ext_addr_bus_out,
  input wire [13:0] ext_addr_bus_oe,
  input wire ad_drv,
  input wire [13:0] ad_val,
  input wire [23:0] ext_data_bus_out,
  input wire [23:0] ext_data_bus_oe,
  input wire dd_drv,
  input wire [23:0] dd_val,
  input wire [4:0] mem_select_n,
  output wire [7:0] pf_in,
  output wire [13:0] ext_addr_bus_in,
  output wire [23:0] ext_data_bus_in,
  output wire periph_sel
);
  // flag pins are pulled up, so a released request line reads inactive
  assign pf_in = (pf_oe & pf_out) | (~pf_oe & (~pf_drv | pf_val));
  // undriven bus lines show the inverse of the last drive so stale data never matches
  wire [13:0] a_far = ad_drv ? ad_val : ~ext_addr_bus_out;
  wire [23:0] d_far = dd_drv ? dd_val : ~ext_data_bus_out;
  assign ext_addr_bus_in = (ext_addr_bus_oe & ext_addr_bus_out)
    | (~ext_addr_bus_oe & a_far);
  assign ext_data_bus_in = (ext_data_bus_oe & ext_data_bus_out)
    | (~ext_data_bus_oe & d_far);
  // peripheral decode from the low address bit and any active select
  assign periph_sel = ext_addr_bus_out[0] & ~&mem_select_n;
endmodule // rmpm_far_model

// *** bench/rmpm_pin_mux_tb_top.sv ***
`timescale 1ns/1ns
module rmpm_pin_mux_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, periph_sel;
  logic [7:0] paddr, pf_in, pf_out, pf_oe, core_byte_addr_hi, pf_drv, pf_val;
  logic [31:0] pwdata, prdata, r;
  logic [2:0] fixed_flag_out;
  logic [4:0] core_mem_select_n, mem_select_n;
  logic [13:0] core_addr, ext_addr_bus_out, ext_addr_bus_oe, ext_addr_bus_in, ad_val;
  logic [23:0] core_wdata, core_rdata, ext_data_bus_out, ext_data_bus_oe, ext_data_bus_in;
  logic [23:0] dd_val;
  logic [15:0] host_core_rdata, host_core_ad;
  logic core_data_drive, core_byte_access, host_core_drive, host_core_ack, ad_drv, dd_drv;
  logic host_write_strobe_n, host_read_strobe_n, host_addr_latch, host_port_select_n;
  logic host_mode, s1_rfs_in, s1_dr_in, s1_tfs_in, s1_dt_core, s1_dt_out, s1_rfs_core;
  logic s1_dr_core, s1_tfs_core, serial1_flag_in;
  int failures, n_checks, k;

  rmpm_pin_mux u_dut (.*);
  rmpm_far_model u_far (.*);

  // 100 mhz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one apb transfer; read data lands in r, the error flag in err
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (k == 16) failures++;
    {r, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask

  // straps are held three edges past release, then the pins float to pull-ups
  task automatic rst(input logic [7:0] straps);
    presetn <= 1'b0;
    {pf_drv, pf_val} <= {8'hff, straps};
    cyc(5);
    presetn <= 1'b1;
    cyc(3);
    pf_drv <= 8'h00;
  endtask

  task automatic done(input string s);
    $display("done %0s", s);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} <= '0;
    {core_addr, core_wdata, core_data_drive, core_byte_access, core_byte_addr_hi} <= '0;
    {host_core_rdata, host_core_drive, host_core_ack, s1_dt_core} <= '0;
    {s1_rfs_in, s1_dr_in, s1_tfs_in, core_mem_select_n} <= 8'hff;
    {ad_drv, ad_val, dd_drv, dd_val} <= '0;
    rst(8'hfb);
    chk(host_mode, 0);
    {pf_drv, pf_val} <= 16'h0404;
    cyc(4);
    apb(0, 8'h04, 0);
    chk({host_mode, r[7:0]}, 9'h00b);
    pf_drv <= 8'h00;
    done("straps");
    {core_addr, core_wdata} <= {14'h2a5c, 24'h123456};
    {core_data_drive, core_mem_select_n} <= {1'b1, 5'h1d};
    cyc(2);
    chk({ext_addr_bus_out, ext_addr_bus_oe}, {14'h2a5c, 14'h3fff});
    chk(ext_data_bus_out, 24'h123456);
    chk({ext_data_bus_oe, mem_select_n}, {24'hffffff, 5'h1d});
    {core_byte_access, core_byte_addr_hi} <= 9'h1c3;
    cyc(2);
    chk(ext_data_bus_out[23:16], 8'hc3);
    {core_data_drive, core_byte_access, dd_drv, dd_val} <= {3'b001, 24'h654321};
    cyc(5);
    chk(ext_data_bus_oe, 0);
    chk(core_rdata, 24'h654321);
    {core_byte_access, dd_drv} <= 2'b00;
    done("bus");
    apb(1, 8'h08, 32'h0f);
    apb(1, 8'h0c, 32'h0a);
    apb(1, 8'h14, 32'h05);
    cyc(2);
    chk({pf_oe, pf_out[3:0], fixed_flag_out}, {8'h0f, 4'ha, 3'h5});
    apb(0, 8'h10, 0);
    chk(r, 32'hfa);
    done("flags");
    apb(1, 8'h1c, 32'h08);
    {pf_drv, pf_val} <= 16'h1000;
    cyc(6);
    chk(irq, 1);
    pf_drv <= 8'h00;
    apb(1, 8'h18, 32'h08);
    apb(0, 8'h18, 0);
    chk({irq, r[7:0]}, 0);
    apb(1, 8'h1c, 32'h04);
    apb(1, 8'h08, 32'h2f);
    cyc(6);
    chk(irq, 1);
    apb(1, 8'h18, 32'h04);
    apb(0, 8'h18, 0);
    chk(r, 32'h04);
    apb(0, 8'h10, 0);
    chk(r, 32'hda);
    apb(1, 8'h0c, 32'h2a);
    cyc(4);
    apb(1, 8'h18, 32'h04);
    cyc(2);
    chk(irq, 0);
    apb(1, 8'h1c, 32'h0);
    {pf_drv, pf_val} <= 16'h8000;
    cyc(5);
    // level then edge sensing on the selectable request, masked throughout
    for (int m = 0; m < 2; m++)
    begin
      apb(1, 8'h00, m * 2);
      apb(1, 8'h18, 32'h01);
      apb(0, 8'h18, 0);
      chk({irq, r[7:0]}, m ? 9'h0 : 9'h1);
    end
    pf_drv <= 8'h00;
    done("irq");
    apb(1, 8'h18, 32'h3f);
    s1_dr_in <= 1'b0;
    cyc(5);
    chk({serial1_flag_in, s1_dr_core}, 2'b10);
    apb(1, 8'h00, 32'h01);
    apb(1, 8'h14, 32'h08);
    s1_tfs_in <= 1'b0;
    cyc(5);
    chk({serial1_flag_in, s1_dr_core, s1_dt_out}, 3'b011);
    apb(0, 8'h18, 0);
    chk(r, 32'h10);
    apb(0, 8'h40, 0);
    chk({err, r[7:0]}, 9'h100);
    done("serial");
    rst(8'hf4);
    apb(0, 8'h04, 0);
    chk({host_mode, r[7:0]}, 9'h114);
    {core_addr, core_wdata} <= {14'h1, 24'habcdef};
    {core_data_drive, core_mem_select_n} <= {1'b1, 5'h1e};
    {ad_drv, ad_val, dd_drv, dd_val} <= {1'b1, 14'h3578, 1'b1, 24'h54};
    cyc(5);
    chk({ext_addr_bus_oe[0], ext_addr_bus_out[0], ext_data_bus_oe[23:8]}, 18'h3ffff);
    chk(ext_data_bus_out[23:8], 16'habcd);
    chk(host_core_ad, 16'h9abc);
    chk({host_write_strobe_n, host_read_strobe_n, host_port_select_n, host_addr_latch, periph_sel},
      5'hd);
    host_core_ack <= 1'b1;
    cyc(2);
    chk({ext_data_bus_oe[3], ext_data_bus_out[3]}, 2'b00);
    host_core_ack <= 1'b0;
    cyc(2);
    chk({ext_data_bus_oe[3], ext_data_bus_out[3]}, 2'b10);
    done("host");
    tally_and_finish;
  end

  // cut a hang short; the full run needs well under 2000 cycles
  initial
  begin
    #50000;
    failures++;
    tally_and_finish;
  end
endmodule // rmpm_pin_mux_tb_top
